// >>> host_bus_model.sv
`timescale 1ns/1ps

// ============================================================================
// Host processor on the parallel bus, with separate strobes or data strobe with direction.
module host_bus_model (
  // Clock.
  input  wire logic       ref_clk,
  // Bus style: high uses the data strobe with a direction pin.
  input  wire logic       combined_strobe,
  // Bus pins.
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic            data_strobe_n,
  output logic            rw_sel,
  output logic            reg_sel_hi,
  output logic            reg_sel_lo,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data_strobe_n = 1'b1;
    rw_sel = 1'b1;
    {reg_sel_hi, reg_sel_lo} = 2'h0;
    data_in = 8'h00;
  end

  // A released data bus shows the inverse so stale bytes cannot pass as fresh.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {reg_sel_hi, reg_sel_lo} <= a;
    data_in <= d;
    rw_sel <= 1'b0;
    cs_n <= 1'b0;
    if (combined_strobe) begin
      data_strobe_n <= 1'b0;
    end else begin
      wr_n <= 1'b0;
    end
    @(posedge ref_clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    data_strobe_n <= 1'b1;
    @(posedge ref_clk);
    data_in <= ~d;
    repeat (3) @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic to);
    int n;
    to = 1'b1;
    d = 8'h00;
    @(posedge ref_clk);
    {reg_sel_hi, reg_sel_lo} <= a;
    rw_sel <= 1'b1;
    cs_n <= 1'b0;
    if (combined_strobe) begin
      data_strobe_n <= 1'b0;
    end else begin
      rd_n <= 1'b0;
    end
    for (n = 0; n < 4 && to; n++) begin
      @(posedge ref_clk);
      if (data_oe === 1'b1) begin
        d = data_out;
        to = 1'b0;
      end
    end
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    data_strobe_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : rd
endmodule : host_bus_model

// >>> host_port_pkg.sv
package host_port_pkg;

  // ==========================================================================
  // Register addresses on the two select pins.
  localparam logic [1:0] ADDR_MSG  = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_PCM  = 2'h2;
  localparam logic [1:0] ADDR_CMP  = 2'h3;

  // ==========================================================================
  // Control/status field positions.
  localparam int CMP_RST_BIT = 6;
  localparam int PCM_RST_BIT = 5;
  localparam int PCM_AF_BIT  = 4;
  localparam int CMP_AF_BIT  = 3;
  localparam int IN_BUSY_BIT = 2;
  localparam int OUT_RDY_BIT = 1;

  // ==========================================================================
  // Widths, reset values and buffer sizing.
  localparam int         DATA_W      = 8;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic       FLAG_RESET  = 1'b0;
  localparam int         FIFO_DEPTH  = 16;
  localparam int         FIFO_AF_LVL = 12;

endpackage : host_port_pkg

// >>> parallel_host_mailbox_port.sv
`timescale 1ns/1ps

// Function
// - Eight-bit port with four selectable registers.
// - Address 0 mailbox, 1 control, 2 PCM, 3 compressed.
// - Mailbox is separate inbound and outbound registers.
// - Control bits 7 and 0 ignored.
// - Control bit 6 holds compressed channel reset.
// - Control bit 5 holds PCM channel reset.
// - Bit 4 shows PCM FIFO almost full.
// - Bit 3 shows compressed FIFO almost full.
// - Inbound busy: host write sets, DSP read clears.
// - Outbound ready: DSP write sets, host read clears.
// - Data ports write-only, bytes pushed into FIFOs.
// - Attention output low while outbound message pending.
// - Device drives selected register during host read.
// - Port disabled while external memory uses pins.
// - Separate strobes or data strobe with direction.

// ============================================================================
// Byte FIFO
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AF_LVL = 12
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Level.
  output logic                  almost_full
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] AF_C    = CW'(AF_LVL);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  assign in_ready    = (count_q != DEPTH_C) && !flush;
  assign out_valid   = (count_q != '0) && !flush;
  assign out_data    = mem_q[rd_ptr_q];
  assign push        = in_valid && in_ready;
  assign pop         = out_valid && out_ready;
  assign almost_full = (count_q >= AF_C);

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap by modulo so any depth works, not only powers of two.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : byte_fifo

// ============================================================================
// Host port top
module parallel_host_mailbox_port #(
  parameter int FIFO_DEPTH  = host_port_pkg::FIFO_DEPTH,
  parameter int FIFO_AF_LVL = host_port_pkg::FIFO_AF_LVL
) (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Host bus pins.
  input  wire logic       cs_n,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic       data_strobe_n,
  input  wire logic       rw_sel,
  input  wire logic       reg_sel_hi,
  input  wire logic       reg_sel_lo,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            host_attention_n,
  // Configuration straps.
  input  wire logic       combined_strobe,
  input  wire logic       ext_mem_mode,
  input  wire logic       notify_en,
  // DSP mailbox side.
  input  wire logic       dsp_msg_rd,
  output logic      [7:0] dsp_inbound_data,
  input  wire logic       dsp_msg_wr,
  input  wire logic [7:0] dsp_msg_data,
  output logic            inbound_busy,
  output logic            outbound_ready,
  // PCM stream.
  output logic            pcm_valid,
  input  wire logic       pcm_ready,
  output logic      [7:0] pcm_data,
  output logic            pcm_space,
  output logic            pcm_channel_reset,
  // Compressed stream.
  output logic            cmp_valid,
  input  wire logic       cmp_ready,
  output logic      [7:0] cmp_data,
  output logic            cmp_space,
  output logic            compressed_channel_reset
);

  logic [1:0] sel;
  logic       port_en;
  logic       wr_act;
  logic       rd_act;
  logic       wr_q;
  logic       rd_q;
  logic       wr_end;
  logic       rd_end;
  logic [1:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] inbound_q;
  logic [7:0] outbound_q;
  logic [7:0] rdata_q;
  logic [7:0] ctrl_rd;
  logic       busy_q;
  logic       ready_q;
  logic       pcm_rst_q;
  logic       cmp_rst_q;
  logic       pcm_af;
  logic       cmp_af;
  logic       pcm_push;
  logic       cmp_push;

  // ==========================================================================
  // Strobe decode. Pins share the memory bus, so the port stays dead while
  // external memory owns them.
  assign sel     = {reg_sel_hi, reg_sel_lo};
  assign port_en = !ext_mem_mode;
  assign wr_act  = port_en && !cs_n && (combined_strobe ?
                   (!data_strobe_n && !rw_sel) : (!wr_n && rd_n));
  assign rd_act  = port_en && !cs_n && (combined_strobe ?
                   (!data_strobe_n && rw_sel) : (!rd_n && wr_n));
  // A cycle takes effect when its strobe is released.
  assign wr_end  = wr_q && !wr_act;
  assign rd_end  = rd_q && !rd_act;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= host_port_pkg::ADDR_MSG;
      wdata_q <= host_port_pkg::BYTE_RESET;
    end else begin
      wr_q <= wr_act;
      rd_q <= rd_act;
      if (wr_act || rd_act) begin
        addr_q <= sel;
      end
      if (wr_act) begin
        wdata_q <= data_in;
      end
    end
  end

  // ==========================================================================
  // Mailbox: two independent bytes plus handshake flags.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inbound_q  <= host_port_pkg::BYTE_RESET;
      outbound_q <= host_port_pkg::BYTE_RESET;
    end else begin
      if (wr_end && addr_q == host_port_pkg::ADDR_MSG) begin
        inbound_q <= wdata_q;
      end
      if (dsp_msg_wr) begin
        outbound_q <= dsp_msg_data;
      end
    end
  end

  // Set is tested first so an event in the clearing cycle is not lost.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q  <= host_port_pkg::FLAG_RESET;
      ready_q <= host_port_pkg::FLAG_RESET;
    end else begin
      if (wr_end && addr_q == host_port_pkg::ADDR_MSG) begin
        busy_q <= 1'b1;
      end else if (dsp_msg_rd) begin
        busy_q <= 1'b0;
      end
      if (dsp_msg_wr) begin
        ready_q <= 1'b1;
      end else if (rd_end && addr_q == host_port_pkg::ADDR_MSG) begin
        ready_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Control register. Bits 7 and 0 are dropped on write.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcm_rst_q <= host_port_pkg::FLAG_RESET;
      cmp_rst_q <= host_port_pkg::FLAG_RESET;
    end else if (wr_end && addr_q == host_port_pkg::ADDR_CTRL) begin
      cmp_rst_q <= wdata_q[host_port_pkg::CMP_RST_BIT];
      pcm_rst_q <= wdata_q[host_port_pkg::PCM_RST_BIT];
    end
  end

  // Write-only and reserved bits read back as zero.
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[host_port_pkg::PCM_AF_BIT]  = pcm_af;
    ctrl_rd[host_port_pkg::CMP_AF_BIT]  = cmp_af;
    ctrl_rd[host_port_pkg::IN_BUSY_BIT] = busy_q;
    ctrl_rd[host_port_pkg::OUT_RDY_BIT] = ready_q;
  end

  // ==========================================================================
  // Read path. Data is registered, so the driver turns on one cycle into
  // the strobe and only for the two readable addresses.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= host_port_pkg::BYTE_RESET;
    end else if (rd_act) begin
      rdata_q <= (sel == host_port_pkg::ADDR_MSG) ? outbound_q : ctrl_rd;
    end
  end

  assign data_out = rdata_q;
  assign data_oe  = rd_act && rd_q && !addr_q[1];

  // ==========================================================================
  // Stream ports. A byte that finds its FIFO full is dropped; the host is
  // expected to pace itself on the almost-full flags.
  assign pcm_push = wr_end && addr_q == host_port_pkg::ADDR_PCM && !pcm_rst_q;
  assign cmp_push = wr_end && addr_q == host_port_pkg::ADDR_CMP && !cmp_rst_q;

  byte_fifo #(
    .WIDTH  (host_port_pkg::DATA_W),
    .DEPTH  (FIFO_DEPTH),
    .AF_LVL (FIFO_AF_LVL)
  ) pcm_fifo (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .flush       (pcm_rst_q),
    .in_valid    (pcm_push),
    .in_ready    (pcm_space),
    .in_data     (wdata_q),
    .out_valid   (pcm_valid),
    .out_ready   (pcm_ready),
    .out_data    (pcm_data),
    .almost_full (pcm_af)
  );

  byte_fifo #(
    .WIDTH  (host_port_pkg::DATA_W),
    .DEPTH  (FIFO_DEPTH),
    .AF_LVL (FIFO_AF_LVL)
  ) cmp_fifo (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .flush       (cmp_rst_q),
    .in_valid    (cmp_push),
    .in_ready    (cmp_space),
    .in_data     (wdata_q),
    .out_valid   (cmp_valid),
    .out_ready   (cmp_ready),
    .out_data    (cmp_data),
    .almost_full (cmp_af)
  );

  // ==========================================================================
  // Outputs.
  assign host_attention_n         = !(notify_en && ready_q);
  assign dsp_inbound_data         = inbound_q;
  assign inbound_busy             = busy_q;
  assign outbound_ready           = ready_q;
  assign pcm_channel_reset        = pcm_rst_q;
  assign compressed_channel_reset = cmp_rst_q;

  // ==========================================================================
  // Checks.
  busy_set_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_end && addr_q == host_port_pkg::ADDR_MSG |=> busy_q)
    else $error("inbound busy did not set on mailbox write");
  busy_clear_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    dsp_msg_rd && !(wr_end && addr_q == host_port_pkg::ADDR_MSG) |=> !busy_q)
    else $error("inbound busy did not clear on DSP read");
  ready_set_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    dsp_msg_wr |=> ready_q && outbound_q == $past(dsp_msg_data))
    else $error("outbound ready did not set on DSP write");
  ready_clear_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_end && addr_q == host_port_pkg::ADDR_MSG && !dsp_msg_wr |=> !ready_q)
    else $error("outbound ready did not clear on host read");
  inbound_load_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_end && addr_q == host_port_pkg::ADDR_MSG |=> inbound_q == $past(wdata_q))
    else $error("inbound mailbox did not take written byte");
  chan_reset_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_end && addr_q == host_port_pkg::ADDR_CTRL |=>
    {cmp_rst_q, pcm_rst_q} == $past(wdata_q[6:5]))
    else $error("channel reset bits not taken from control write");
  pcm_flush_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    pcm_rst_q |-> !pcm_space ##1 !pcm_valid)
    else $error("PCM FIFO not emptied while channel held in reset");
  pcm_push_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    pcm_push && pcm_space && !pcm_valid |=> pcm_valid && pcm_data == $past(wdata_q))
    else $error("PCM byte not pushed into FIFO");
  read_mbox_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    data_oe && addr_q == host_port_pkg::ADDR_MSG |-> data_out == $past(outbound_q))
    else $error("mailbox read drove wrong byte");
  ext_mem_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    ext_mem_mode |=> !data_oe && !pcm_push && !cmp_push)
    else $error("host port active in external memory mode");
  attention_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
    dsp_msg_wr && notify_en |=> !host_attention_n)
    else $error("attention not raised for pending message");

endmodule : parallel_host_mailbox_port

// >>> parallel_host_mailbox_port_test.sv
`timescale 1ns/1ps

module parallel_host_mailbox_port_test;
  logic ref_clk = 1'b0, rst_n = 1'b0, ext_mem_mode = 1'b0, notify_en = 1'b0;
  logic dsp_msg_rd = 1'b0, dsp_msg_wr = 1'b0, pcm_ready = 1'b0, cmp_ready = 1'b0;
  logic [7:0] dsp_msg_data = 8'h00, data_in, data_out, dsp_inbound_data, pcm_data, cmp_data;
  logic cs_n, wr_n, rd_n, reg_sel_hi, reg_sel_lo, data_oe, host_attention_n;
  logic inbound_busy, outbound_ready, pcm_valid, pcm_space, pcm_channel_reset;
  logic cmp_valid, cmp_space, compressed_channel_reset, eb = 1'b0, er = 1'b0, to;
  logic combined_strobe = 1'b0, data_strobe_n, rw_sel;
  logic [7:0] b, d;
  logic [7:0] q[2][$];
  int error_cnt = 0, check_count = 0, n;

  always #25 ref_clk = ~ref_clk;

  host_bus_model u_host (.ref_clk(ref_clk), .combined_strobe(combined_strobe),
    .data_strobe_n(data_strobe_n), .rw_sel(rw_sel), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .reg_sel_hi(reg_sel_hi), .reg_sel_lo(reg_sel_lo), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe));

  parallel_host_mailbox_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .data_strobe_n(data_strobe_n), .rw_sel(rw_sel),
    .reg_sel_hi(reg_sel_hi), .reg_sel_lo(reg_sel_lo), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .host_attention_n(host_attention_n),
    .combined_strobe(combined_strobe), .ext_mem_mode(ext_mem_mode), .notify_en(notify_en),
    .dsp_msg_rd(dsp_msg_rd), .dsp_inbound_data(dsp_inbound_data),
    .dsp_msg_wr(dsp_msg_wr), .dsp_msg_data(dsp_msg_data), .inbound_busy(inbound_busy),
    .outbound_ready(outbound_ready), .pcm_valid(pcm_valid), .pcm_ready(pcm_ready),
    .pcm_data(pcm_data), .pcm_space(pcm_space), .pcm_channel_reset(pcm_channel_reset),
    .cmp_valid(cmp_valid), .cmp_ready(cmp_ready), .cmp_data(cmp_data),
    .cmp_space(cmp_space), .compressed_channel_reset(compressed_channel_reset));

  task automatic report_and_stop();
    $display("checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] ctrl_exp();
    return {3'h0, q[0].size() >= host_port_pkg::FIFO_AF_LVL,
            q[1].size() >= host_port_pkg::FIFO_AF_LVL, eb, er, 1'b0};
  endfunction : ctrl_exp

  task automatic rdctl();
    u_host.rd(host_port_pkg::ADDR_CTRL, d, to);
    chk("status answer", 8'(to), 8'h00);
    chk("status", d, ctrl_exp());
  endtask : rdctl

  task automatic dsp(input logic w, input logic [7:0] v);
    @(posedge ref_clk);
    dsp_msg_wr <= w;
    dsp_msg_rd <= !w;
    dsp_msg_data <= v;
    @(posedge ref_clk);
    dsp_msg_wr <= 1'b0;
    dsp_msg_rd <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : dsp

  // Fills one channel past full with the drain stalled, then drains with random stalls.
  task automatic fd(input logic ch);
    logic rdy;
    int k;
    rdy = 1'b0;
    for (k = 0; k < 17; k++) begin
      b = 8'($urandom);
      u_host.wr(ch ? host_port_pkg::ADDR_CMP : host_port_pkg::ADDR_PCM, b);
      if (k < host_port_pkg::FIFO_DEPTH) q[ch].push_back(b);
      if (k == 10 || k == 11 || k == 16) rdctl();
    end
    chk("space when full", 8'(ch ? cmp_space : pcm_space), 8'h00);
    for (k = 0; k < 300 && q[ch].size() > 0; k++) begin
      @(posedge ref_clk);
      if ((ch ? cmp_valid : pcm_valid) === 1'b1 && rdy) begin
        chk("fifo byte", ch ? cmp_data : pcm_data, q[ch].pop_front());
      end
      rdy = 1'($urandom_range(1, 0));
      pcm_ready <= rdy & !ch;
      cmp_ready <= rdy & ch;
    end
    if (q[ch].size() > 0) begin
      error_cnt++;
      report_and_stop();
    end
    pcm_ready <= 1'b0;
    cmp_ready <= 1'b0;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chk("empty after drain", 8'(ch ? cmp_valid : pcm_valid), 8'h00);
  endtask : fd

  initial begin
    void'($urandom(32'hca4c));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("attention idle", 8'(host_attention_n), 8'h01);
    rdctl();
    // Two mailbox bytes go in, each taken by a DSP read before the next.
    for (n = 0; n < 2; n++) begin
      rdctl();
      b = 8'($urandom);
      u_host.wr(host_port_pkg::ADDR_MSG, b);
      eb = 1'b1;
      chk("inbound byte", dsp_inbound_data, b);
      rdctl();
      dsp(1'b0, 8'h00);
      eb = 1'b0;
      chk("inbound busy", 8'(inbound_busy), 8'h00);
    end
    b = 8'($urandom);
    dsp(1'b1, b);
    er = 1'b1;
    chk("attention masked", 8'(host_attention_n), 8'h01);
    notify_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("attention on", 8'(host_attention_n), 8'h00);
    rdctl();
    u_host.rd(host_port_pkg::ADDR_MSG, d, to);
    er = 1'b0;
    chk("outbound byte", d, b);
    chk("outbound ready", 8'(outbound_ready), 8'h00);
    chk("attention off", 8'(host_attention_n), 8'h01);
    u_host.rd(host_port_pkg::ADDR_PCM, d, to);
    chk("data port read refused", 8'(to), 8'h01);
    ext_mem_mode <= 1'b1;
    u_host.wr(host_port_pkg::ADDR_MSG, 8'h5a);
    chk("busy in memory mode", 8'(inbound_busy), 8'h00);
    u_host.rd(host_port_pkg::ADDR_CTRL, d, to);
    chk("read in memory mode", 8'(to), 8'h01);
    ext_mem_mode <= 1'b0;
    u_host.wr(host_port_pkg::ADDR_PCM, 8'h3c);
    chk("pcm byte waiting", 8'(pcm_valid), 8'h01);
    u_host.wr(host_port_pkg::ADDR_CTRL, 8'ha1);
    chk("pcm reset", 8'(pcm_channel_reset), 8'h01);
    chk("cmp reset", 8'(compressed_channel_reset), 8'h00);
    chk("pcm flushed", 8'(pcm_valid), 8'h00);
    rdctl();
    u_host.wr(host_port_pkg::ADDR_PCM, 8'($urandom));
    chk("pcm held", 8'(pcm_valid), 8'h00);
    u_host.wr(host_port_pkg::ADDR_CTRL, 8'h40);
    chk("cmp reset", 8'(compressed_channel_reset), 8'h01);
    chk("pcm released", 8'(pcm_channel_reset), 8'h00);
    u_host.wr(host_port_pkg::ADDR_CMP, 8'($urandom));
    chk("cmp held", 8'(cmp_valid), 8'h00);
    u_host.wr(host_port_pkg::ADDR_CTRL, 8'h00);
    // The same mailbox exchange again with the data strobe and direction pin.
    combined_strobe <= 1'b1;
    b = 8'($urandom);
    u_host.wr(host_port_pkg::ADDR_MSG, b);
    eb = 1'b1;
    chk("strobe style inbound", dsp_inbound_data, b);
    rdctl();
    dsp(1'b0, 8'h00);
    eb = 1'b0;
    b = 8'($urandom);
    dsp(1'b1, b);
    er = 1'b1;
    chk("attention pending", 8'(host_attention_n), 8'h00);
    rdctl();
    u_host.rd(host_port_pkg::ADDR_MSG, d, to);
    er = 1'b0;
    chk("strobe style outbound", d, b);
    chk("strobe style ready", 8'(outbound_ready), 8'h00);
    combined_strobe <= 1'b0;
    fd(1'b0);
    fd(1'b1);
    report_and_stop();
  end
endmodule : parallel_host_mailbox_port_test
